// ### rtl/sfepd_sequencer.sv
/*
  Command sequencer of a serial NOR flash: whole-array erase, page write,
  secure-area erase/write/read and sleep entry/release.
  Assumes the host frames commands with chip select; the serial clock only
  runs inside frames. Array contents are modelled by a page buffer and
  secure area memory; the array itself is outside, reached via job ports.
*/
`timescale 1ns/100ps
`default_nettype none
module sfepd_sequencer (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        linkClk,        // Serial clock from host
  input  wire logic        chipSelectN,    // Active low frame
  input  wire logic        serialIn,
  output logic             serialOut,
  output logic             serialOutEn,
  input  wire logic [4:0]  blockProtectBits,
  input  wire logic [2:0]  secureAreaLockBits,
  input  wire logic        writeEnableSet, // Pulse from write unlock logic
  output logic             writeEnableLatch,
  output logic             writeInProgress,
  output logic             sleeping,
  output logic             arrayEraseStart, // Pulse: erase whole array to ones
  output logic             pageWriteStart,  // Pulse: commit page buffer
  output logic [23:0]      pageWriteAddr
);

  // Link-domain state
  typedef struct packed {
    logic [7:0]        shift;
    logic [2:0]        bitCnt;
    logic [31:0]       byteCnt;
    logic [7:0]        opcode;
    logic [23:0]       addr;
    logic [7:0]        wrPtr;   // Page write pointer, start address kept in addr
    sfepd_pkg::sfepd_wr_s wr;
  } sfepd_link_s;

  sfepd_link_s lnk, next_lnk, base;
  logic [7:0]  rxByte;
  logic        rxDone;
  logic        frameOpen;       // Low until the first clock of a frame
  logic [8:0]  rdIdx;
  logic [7:0]  outByte;

  // Page buffer and secure areas (3 x 512 bytes)
  logic [7:0]  pageBuf   [0:255];
  logic [7:0]  secureMem [0:1535];
  logic [10:0] secBase;

  // Frame fields start from zero at the first clock, but stay readable after chip select rises
  assign base   = frameOpen ? lnk : '0;
  assign rxByte = {base.shift[6:0], serialIn};
  assign rxDone = (base.bitCnt == 3'h7);
  assign secBase = 11'((lnk.addr[15:12] - 4'h1) * 10'h200);

  // Shift in on rising serial clock; frame reset by chip select
  always_comb begin
    next_lnk = base;
    next_lnk.wr.en = 1'b0;
    next_lnk.shift = rxByte;
    next_lnk.bitCnt = base.bitCnt + 3'h1;
    if (rxDone) begin
      next_lnk.byteCnt = base.byteCnt + 32'h1;
      if (base.byteCnt == 32'h0) begin
        next_lnk.opcode = rxByte;
      end else if (base.byteCnt < 32'h4) begin
        next_lnk.addr  = {base.addr[15:0], rxByte};
        next_lnk.wrPtr = rxByte;
      end else if (base.opcode == sfepd_pkg::OP_PAGE_WRITE ||
                   base.opcode == sfepd_pkg::OP_SECURE_WRITE) begin
        next_lnk.wr.en   = 1'b1;
        next_lnk.wr.idx  = {1'b0, base.wrPtr};
        next_lnk.wr.data = rxByte;
        next_lnk.wrPtr   = base.wrPtr + 8'h1;
      end
    end
  end

  // Frame marker, cleared as chip select rises
  always_ff @(posedge linkClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      frameOpen <= 1'b0;
    end else begin
      frameOpen <= 1'b1;
    end
  end

  // Frame fields hold after the frame so the core can decode them
  always_ff @(posedge linkClk) begin
    lnk <= next_lnk;
  end

  // Last 256 bytes win; last byte lands on its own eighth edge
  always_ff @(posedge linkClk) begin
    if (next_lnk.wr.en) begin
      pageBuf[next_lnk.wr.idx[7:0]] <= next_lnk.wr.data;
    end
  end

  // Secure read out on falling edge; wrap in area
  always_ff @(negedge linkClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      rdIdx       <= 9'h000;
      outByte     <= 8'h00;
      serialOutEn <= 1'b0;
    end else begin
      serialOutEn <= (lnk.opcode == sfepd_pkg::OP_SECURE_READ) && (lnk.byteCnt >= 32'h5);
      if (lnk.byteCnt == 32'h4 && lnk.bitCnt == 3'h0) begin
        rdIdx <= lnk.addr[8:0];
      end else if (lnk.byteCnt >= 32'h5 && lnk.bitCnt == 3'h0) begin
        outByte <= secureMem[11'(secBase + 11'(rdIdx))];
        rdIdx   <= rdIdx + 9'h001;
      end else begin
        outByte <= {outByte[6:0], 1'b0};
      end
    end
  end

  // Output bit straight from the shift flop
  always_comb begin
    serialOut = outByte[7];
  end

  // Frame end crosses by two-flop sync of chip select
  logic [2:0] csSync;
  logic       frameEnd;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      csSync <= 3'b111;
    end else begin
      csSync <= {csSync[1:0], chipSelectN};
    end
  end
  assign frameEnd = csSync[1] & ~csSync[2];

  // Core state
  typedef struct packed {
    sfepd_pkg::sfepd_job_e job;
    logic [23:0]           timer;
    logic                  write_enable_latch;
    logic                  asleep;
    logic                  eraseSecure;
    logic                  eraseArray;
    logic                  commitPage;
    logic [23:0]           jobAddr;
  } sfepd_core_s;

  sfepd_core_s cor, next_cor;
  logic        protectedHit;
  logic        secureSel;
  logic        locked;

  // Link fields are stable while chip select is high, so sampling is safe
  assign secureSel = (lnk.addr[23:16] == 8'h00) && (lnk.addr[11:9] == 3'h0) &&
                     (lnk.addr[15:12] >= sfepd_pkg::SECURE_SEL_LO) &&
                     (lnk.addr[15:12] <= sfepd_pkg::SECURE_SEL_HI);
  assign locked = |secureAreaLockBits;
  assign protectedHit = (blockProtectBits != sfepd_pkg::PROTECT_NONE);

  always_comb begin
    next_cor = cor;
    next_cor.eraseArray = 1'b0;
    next_cor.commitPage = 1'b0;
    next_cor.eraseSecure = 1'b0;
    if (writeEnableSet && !cor.asleep) begin
      next_cor.write_enable_latch = 1'b1;
    end
    if (cor.job != sfepd_pkg::JOB_IDLE) begin
      next_cor.timer = cor.timer - 24'h1;
      if (cor.timer == 24'h1) begin
        next_cor.job = sfepd_pkg::JOB_IDLE;
        if (cor.job == sfepd_pkg::JOB_ERASE || cor.job == sfepd_pkg::JOB_WRITE) begin
          next_cor.write_enable_latch = 1'b0;
        end
        if (cor.job == sfepd_pkg::JOB_SLEEP) begin
          next_cor.asleep = 1'b1;
        end
        if (cor.job == sfepd_pkg::JOB_WAKE) begin
          next_cor.asleep = 1'b0;
        end
      end
    end else if (frameEnd) begin
      if (cor.asleep) begin
        if ((lnk.opcode == sfepd_pkg::OP_SLEEP_RELEASE && lnk.byteCnt == 32'h1 &&
             lnk.bitCnt == 3'h0) ||
            lnk.opcode == sfepd_pkg::OP_RESET_DEVICE) begin
          next_cor.job   = sfepd_pkg::JOB_WAKE;
          next_cor.timer = 24'(sfepd_pkg::SLEEP_EXIT_CYC);
        end
      end else if (lnk.opcode == sfepd_pkg::OP_SLEEP_ENTER && lnk.byteCnt == 32'h1) begin
        next_cor.job   = sfepd_pkg::JOB_SLEEP;
        next_cor.timer = 24'(sfepd_pkg::SLEEP_ENTRY_CYC);
      end else if (cor.write_enable_latch && lnk.bitCnt == 3'h0) begin
        if ((lnk.opcode == sfepd_pkg::OP_ARRAY_ERASE_A ||
             lnk.opcode == sfepd_pkg::OP_ARRAY_ERASE_B) && lnk.byteCnt == 32'h1 &&
            !protectedHit) begin
          next_cor.job        = sfepd_pkg::JOB_ERASE;
          next_cor.eraseArray = 1'b1;
          next_cor.timer      = 24'(sfepd_pkg::ARRAY_ERASE_CYC);
        end else if (lnk.opcode == sfepd_pkg::OP_PAGE_WRITE && lnk.byteCnt > 32'h4 &&
                     !protectedHit) begin
          next_cor.job        = sfepd_pkg::JOB_WRITE;
          next_cor.commitPage = 1'b1;
          next_cor.jobAddr    = lnk.addr;
          next_cor.timer      = 24'(sfepd_pkg::PAGE_WRITE_CYC);
        end else if (lnk.opcode == sfepd_pkg::OP_SECURE_ERASE && lnk.byteCnt == 32'h4 &&
                     !locked && secureSel) begin
          next_cor.job         = sfepd_pkg::JOB_ERASE;
          next_cor.eraseSecure = 1'b1;
          next_cor.jobAddr     = lnk.addr;
          next_cor.timer       = 24'(sfepd_pkg::SECTOR_ERASE_CYC);
        end else if (lnk.opcode == sfepd_pkg::OP_SECURE_WRITE && lnk.byteCnt > 32'h4 &&
                     !locked && secureSel) begin
          next_cor.job        = sfepd_pkg::JOB_WRITE;
          next_cor.jobAddr    = lnk.addr;
          next_cor.timer      = 24'(sfepd_pkg::PAGE_WRITE_CYC);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cor <= '{job: sfepd_pkg::JOB_IDLE, timer: sfepd_pkg::TIMER_RESET, default: '0};
    end else begin
      cor <= next_cor;
    end
  end

  // Secure area update in core domain while link is idle
  always_ff @(posedge core_clk) begin
    if (next_cor.job == sfepd_pkg::JOB_WRITE && cor.job == sfepd_pkg::JOB_IDLE &&
        lnk.opcode == sfepd_pkg::OP_SECURE_WRITE) begin
      for (int i = 0; i < sfepd_pkg::PAGE_BYTES; i++) begin
        secureMem[11'(secBase + 11'({lnk.addr[8], 8'(i)}))] <=
          secureMem[11'(secBase + 11'({lnk.addr[8], 8'(i)}))] & pageBuf[i];
      end
    end else if (cor.eraseSecure) begin
      for (int i = 0; i < sfepd_pkg::SECURE_BYTES; i++) begin
        secureMem[11'(11'((cor.jobAddr[15:12] - 4'h1) * 10'h200) + 11'(i))] <= 8'hff;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      writeEnableLatch <= 1'b0;
      writeInProgress  <= 1'b0;
      sleeping         <= 1'b0;
      arrayEraseStart  <= 1'b0;
      pageWriteStart   <= 1'b0;
      pageWriteAddr    <= 24'h000000;
    end else begin
      writeEnableLatch <= next_cor.write_enable_latch;
      writeInProgress  <= (next_cor.job == sfepd_pkg::JOB_ERASE) ||
                          (next_cor.job == sfepd_pkg::JOB_WRITE);
      sleeping         <= next_cor.asleep;
      arrayEraseStart  <= next_cor.eraseArray;
      pageWriteStart   <= next_cor.commitPage;
      pageWriteAddr    <= next_cor.jobAddr;
    end
  end

endmodule
`default_nettype wire

// ### rtl/sfepd_pkg.sv
/*
  Package for the serial flash erase/program/power-down sequencer.
  Holds opcodes, geometry, timing figures and the carrier structs.
  Assumes the core clock runs at 50 MHz and the serial clock comes from the host.
*/
package sfepd_pkg;

  // Core clock period in ns
  localparam int CLK_NS = 20;

  // Opcodes
  localparam logic [7:0] OP_ARRAY_ERASE_A   = 8'h60;
  localparam logic [7:0] OP_ARRAY_ERASE_B   = 8'hc7;
  localparam logic [7:0] OP_PAGE_WRITE      = 8'h02;
  localparam logic [7:0] OP_SECURE_ERASE    = 8'h44;
  localparam logic [7:0] OP_SECURE_WRITE    = 8'h42;
  localparam logic [7:0] OP_SECURE_READ     = 8'h48;
  localparam logic [7:0] OP_SLEEP_ENTER     = 8'hb9;
  localparam logic [7:0] OP_SLEEP_RELEASE   = 8'hab;
  localparam logic [7:0] OP_WRITE_UNLOCK    = 8'h06;
  localparam logic [7:0] OP_RESET_ENABLE    = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE    = 8'h99;

  // Geometry
  localparam int          PAGE_BYTES        = 256;
  localparam int          SECURE_BYTES      = 512;
  localparam logic [4:0]  PROTECT_NONE      = 5'h00;
  localparam logic [3:0]  SECURE_SEL_LO     = 4'h1;
  localparam logic [3:0]  SECURE_SEL_HI     = 4'h3;

  // Timing figures in microseconds, with derived cycle counts
  localparam int ARRAY_ERASE_US      = 2000;
  localparam int PAGE_WRITE_US       = 500;
  localparam int SECTOR_ERASE_US     = 1000;
  localparam int SLEEP_ENTRY_US      = 3;
  localparam int SLEEP_EXIT_US       = 8;
  localparam int ARRAY_ERASE_CYC     = ARRAY_ERASE_US * 1000 / CLK_NS;
  localparam int PAGE_WRITE_CYC      = PAGE_WRITE_US * 1000 / CLK_NS;
  localparam int SECTOR_ERASE_CYC    = SECTOR_ERASE_US * 1000 / CLK_NS;
  localparam int SLEEP_ENTRY_CYC     = (SLEEP_ENTRY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_EXIT_CYC      = (SLEEP_EXIT_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Reset values
  localparam logic [23:0] TIMER_RESET = 24'h000000;

  // Self-timed job kinds
  typedef enum logic [4:0] {
    JOB_IDLE   = 5'b00001,
    JOB_ERASE  = 5'b00010,
    JOB_WRITE  = 5'b00100,
    JOB_SLEEP  = 5'b01000,
    JOB_WAKE   = 5'b10000
  } sfepd_job_e;

  // Command handed from link domain to core domain at frame end
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic        aligned;   // Frame ended on a byte boundary
    logic [31:0] byteCount; // Bytes after opcode
  } sfepd_cmd_s;

  // Memory write port from link domain
  typedef struct packed {
    logic        en;
    logic [8:0]  idx;
    logic [7:0]  data;
  } sfepd_wr_s;

endpackage

// ### test/sfepd_host_model.sv
/* Serial host model: frames, bytes out on SI, bytes in from SO.
   Assumes the caller leaves frames spaced by the gaps kept here. */
`timescale 1ns/100ps
`default_nettype none
module sfepd_host_model (
  output logic      linkClk,
  output logic      chipSelectN,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  // Idle bus, clock parked low
  initial begin
    linkClk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
  end
  task automatic csLow();
    #100 chipSelectN = 1'b0;
  endtask
  // select held high long after frame
  task automatic csHigh();
    #16 chipSelectN = 1'b1;
    serialIn = ~serialIn;
    #200;
  endtask
  task automatic sendBit(input logic b);
    serialIn = b;
    #16 linkClk = 1'b1;
    #16 linkClk = 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) sendBit(b[i]);
  endtask
  task automatic readByte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      serialIn = ~serialIn;
      #16 linkClk = 1'b1;
      b = {b[6:0], serialOut};
      #16 linkClk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### test/sfepd_sequencer_properties.sv
/* Checker on the sequencer's ports, bound below.
   Assumes one core clock domain with a synchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module sfepd_sequencer_properties (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        chipSelectN,
  input wire logic [4:0]  blockProtectBits,
  input wire logic [2:0]  secureAreaLockBits,
  input wire logic        writeEnableLatch,
  input wire logic        writeInProgress,
  input wire logic        sleeping,
  input wire logic        arrayEraseStart,
  input wire logic        pageWriteStart
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [23:0] wipLen;
  logic        jobStart;
  assign jobStart = pageWriteStart | arrayEraseStart;
  // Length of the current busy stretch
  always_ff @(posedge core_clk) begin
    wipLen <= (sys_rst | ~writeInProgress) ? 24'h000000 : wipLen + 24'h000001;
  end
  sequence seqHeld;
    writeInProgress [*8];
  endsequence
  sequence seqFramed;
    $past(chipSelectN) && $past(chipSelectN, 2);
  endsequence
  AST_START_BUSY: assert property (jobStart |-> seqHeld)
    else $error("busy flag not held after job start");
  AST_LATCH_NEEDED: assert property (jobStart |-> $past(writeEnableLatch))
    else $error("job started without latch");
  AST_PROTECT_NONE: assert property (arrayEraseStart |-> $past(blockProtectBits) == 5'h00)
    else $error("erase started while protected");
  AST_IDLE_ONLY: assert property (jobStart |-> !$past(writeInProgress))
    else $error("job started while busy");
  AST_AFTER_FRAME: assert property (jobStart |-> seqFramed)
    else $error("job started inside a frame");
  AST_ASLEEP_QUIET: assert property (sleeping |-> !jobStart)
    else $error("job started while asleep");
  AST_LATCH_CLEARED: assert property ($fell(writeInProgress) |-> !writeEnableLatch)
    else $error("latch still set after job");
  AST_JOB_LENGTH: assert property ($fell(writeInProgress) |->
    (wipLen + 1 >= sfepd_pkg::PAGE_WRITE_CYC && wipLen <= sfepd_pkg::PAGE_WRITE_CYC + 1)
    || (wipLen + 1 >= sfepd_pkg::SECTOR_ERASE_CYC && wipLen <= sfepd_pkg::SECTOR_ERASE_CYC + 1)
    || (wipLen + 1 >= sfepd_pkg::ARRAY_ERASE_CYC))
    else $error("busy stretch of wrong length");
  AST_LOCK_BLOCKS: assert property ($rose(writeInProgress) && !jobStart
    |-> $past(secureAreaLockBits) == 3'h0)
    else $error("secure job ran while locked");
endmodule
bind sfepd_sequencer sfepd_sequencer_properties chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .chipSelectN(chipSelectN), .blockProtectBits(blockProtectBits),
  .secureAreaLockBits(secureAreaLockBits), .writeEnableLatch(writeEnableLatch),
  .writeInProgress(writeInProgress), .sleeping(sleeping),
  .arrayEraseStart(arrayEraseStart), .pageWriteStart(pageWriteStart));
`default_nettype wire

// ### test/serial_flash_erase_program_powerdown_test.sv
/* Self-checking bench for the sequencer with a serial host model.
   Assumes the package timing figures; job starts are noted in a queue. */
`timescale 1ns/100ps
`default_nettype none
module serial_flash_erase_program_powerdown_test;
  logic core_clk, sys_rst, linkClk, chipSelectN, serialIn, serialOut, serialOutEn;
  logic writeEnableSet, writeEnableLatch, writeInProgress, sleeping;
  logic arrayEraseStart, pageWriteStart;
  logic [4:0]  blockProtectBits;
  logic [2:0]  secureAreaLockBits;
  logic [23:0] pageWriteAddr;
  logic [25:0] notes[$];
  logic [7:0]  rd;
  int fails, samples_checked, cycles, seed;
  sfepd_host_model host (.linkClk(linkClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn));
  sfepd_sequencer uut (.core_clk(core_clk), .sys_rst(sys_rst), .linkClk(linkClk),
    .chipSelectN(chipSelectN), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .blockProtectBits(blockProtectBits),
    .secureAreaLockBits(secureAreaLockBits), .writeEnableSet(writeEnableSet),
    .writeEnableLatch(writeEnableLatch), .writeInProgress(writeInProgress),
    .sleeping(sleeping), .arrayEraseStart(arrayEraseStart),
    .pageWriteStart(pageWriteStart), .pageWriteAddr(pageWriteAddr));
  // Core clock, 20 ns
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog on the whole run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 90000) begin
      fails++;
      give_verdict();
    end
  end
  // Each job start is matched to the oldest note
  always @(posedge core_clk) begin
    if (pageWriteStart === 1'b1 || arrayEraseStart === 1'b1) begin
      if (notes.size() == 0) check(1, 0);
      else check({arrayEraseStart, pageWriteStart, pageWriteAddr}, notes.pop_front());
    end
  end
  task automatic unlock();
    @(posedge core_clk) writeEnableSet <= 1'b1;
    @(posedge core_clk) writeEnableSet <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nAddr,
                       input int nData, input logic extra);
    host.csLow();
    host.sendByte(op);
    for (int i = nAddr - 1; i >= 0; i--) host.sendByte(a[8*i +: 8]);
    for (int i = 0; i < nData; i++) host.sendByte(8'(i + 8'h5a));
    if (extra) host.sendBit(1'b1);
    host.csHigh();
    repeat (8) @(posedge core_clk);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 26000 && writeInProgress !== 1'b0; i++) @(posedge core_clk);
  endtask
  task automatic hit(input logic [7:0] op);
    sys_rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(writeEnableLatch, 0);
    if (op != 8'h00) begin
      unlock();
      notes.push_back({2'b10, 24'h000000});
      frame(op, 0, 0, 0, 0);
      check(writeInProgress, 1);
    end
  endtask
  // Main sequence
  initial begin
    seed = 32'h8f28;
    {blockProtectBits, secureAreaLockBits, writeEnableSet} = '0;
    hit(8'h00);
    frame(8'h02, 24'h001234, 3, 2, 0);
    unlock();
    frame(8'h02, 24'h001234, 3, 2, 1);
    blockProtectBits <= 5'($random(seed)) | 5'h01;
    frame(8'h60, 0, 0, 0, 0);
    blockProtectBits <= 5'h00;
    notes.push_back({2'b01, 24'h001234});
    frame(8'h02, 24'h001234, 3, 258, 0);
    frame(8'hc7, 0, 0, 0, 0);
    waitIdle();
    check(writeEnableLatch, 0);
    $display("page write done");
    unlock();
    secureAreaLockBits <= 3'($random(seed)) | 3'h1;
    frame(8'h42, 24'h0011ff, 3, 2, 0);
    check(writeInProgress, 0);
    secureAreaLockBits <= 3'h0;
    frame(8'h42, 24'h0041ff, 3, 2, 0);
    check(writeInProgress, 0);
    frame(8'h44, 24'h001000, 3, 0, 0);
    check(writeInProgress, 1);
    hit(8'h00);
    unlock();
    frame(8'h42, 24'h0011ff, 3, 2, 0);
    check(writeInProgress, 1);
    waitIdle();
    host.csLow();
    host.sendByte(8'h48);
    host.sendByte(8'h00);
    host.sendByte(8'h11);
    host.sendByte(8'hff);
    host.sendByte(8'h00);
    for (int i = 0; i < 258; i++) begin
      host.readByte(rd);
      if (i == 0) check(rd, 8'h5a);
      if (i == 257) check(rd, 8'h5b);
    end
    host.csHigh();
    $display("secure area done");
    frame(8'hb9, 0, 0, 0, 0);
    repeat (sfepd_pkg::SLEEP_ENTRY_CYC + 4) @(posedge core_clk);
    check(sleeping, 1);
    unlock();
    frame(8'h60, 0, 0, 0, 0);
    frame(8'hab, 0, 0, 0, 1);
    check(sleeping, 1);
    frame(8'hab, 0, 0, 0, 0);
    repeat (sfepd_pkg::SLEEP_EXIT_CYC + 4) @(posedge core_clk);
    check(sleeping, 0);
    $display("sleep done");
    hit(8'h60);
    hit(8'hc7);
    hit(8'h00);
    check(notes.size(), 0);
    $display("array erase done");
    give_verdict();
  end
endmodule
`default_nettype wire
